// ===== rtl/adcs_top.sv
// Converter control: registers, channel mux control, prescaler, sequencing.
// Assumes a synchronous CPU register port and an analog core that answers per tick.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module adcs_top #(
  parameter int NUM_PINS = adcs_pkg::NUM_EXT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic crystal_clock_i,
  input wire logic [7:0] core_sample_i,
  input wire logic [NUM_PINS-1:0] port_in_i,
  output logic [NUM_PINS-1:0] pin_analog_o,
  output logic [NUM_PINS-1:0] port_read_o,
  output logic conv_irq_o,
  output adcs_pkg::adcs_core_ctl_t core_ctl_o
);
  import adcs_pkg::*;

  adcs_bus_t bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic [7:0] status_control;
  logic [7:0] next_status_control;
  logic [7:0] clock_setup;
  logic [7:0] next_clock_setup;
  logic [7:0] conversion_result;
  logic [7:0] next_conversion_result;
  logic [7:0] next_rdata;
  logic irq_pending;
  logic next_irq_pending;
  logic first_done;
  logic next_first_done;
  adcs_state_t state;
  adcs_state_t next_state;
  logic [4:0] tick_count;
  logic [4:0] next_tick_count;
  logic [3:0] div_count;
  logic [3:0] next_div_count;
  logic xtal_q;
  logic xtal_qq;
  logic xtal_prev;
  logic conv_tick;
  logic next_conv_tick;
  adcs_core_ctl_t next_core_ctl;
  logic [NUM_PINS-1:0] next_pin_analog;
  logic [NUM_PINS-1:0] next_port_read;

  wire logic status_wr = bus.wr && bus.addr == OFF_STATUS_CONTROL;
  wire logic result_rd = bus.rd && bus.addr == OFF_RESULT;
  wire logic [4:0] channel_selector = status_control[CHAN_LSB +: CHAN_W];
  wire logic conv_irq_enable = status_control[IRQ_EN_BIT];
  wire logic continuous_convert = status_control[CONT_BIT];
  wire logic [2:0] clock_prescaler = clock_setup[PRESC_LSB +: PRESC_W];
  wire logic input_clock_source = clock_setup[SRC_BIT];
  wire logic powered = channel_selector != CH_POWER_OFF;
  wire logic conv_done = state == ST_CONV && conv_tick && tick_count == CONV_TICKS - 5'h01;

  // Divide ratio mask: 0,1,3,7 or 15
  function automatic logic [3:0] div_mask(input logic [2:0] code);
    if (code[2]) begin
      div_mask = 4'hF;
    end else begin
      case (code[1:0])
        2'b00: div_mask = 4'h0;
        2'b01: div_mask = 4'h1;
        2'b10: div_mask = 4'h3;
        default: div_mask = 4'h7;
      endcase
    end
  endfunction : div_mask

  // Classify a channel code as external input
  function automatic logic is_external(input logic [4:0] ch);
    is_external = ch <= CH_LAST_EXT;
  endfunction : is_external

  // Crystal clock sampled as a level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_q <= 1'b0;
      xtal_qq <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_q <= crystal_clock_i;
      xtal_qq <= xtal_q;
      xtal_prev <= xtal_qq;
    end
  end

  // Prescaler
  always_comb begin
    logic src_edge;
    src_edge = 1'b0;
    next_div_count = div_count;
    next_conv_tick = 1'b0;
    src_edge = input_clock_source ? 1'b1 : (xtal_qq && !xtal_prev);
    if (src_edge) begin
      if (div_count >= div_mask(clock_prescaler)) begin
        next_div_count = 4'h0;
        next_conv_tick = 1'b1;
      end else begin
        next_div_count = div_count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_count <= 4'h0;
      conv_tick <= 1'b0;
    end else begin
      div_count <= next_div_count;
      conv_tick <= next_conv_tick;
    end
  end

  // Registers, flags and sequencing
  always_comb begin
    next_status_control = status_control;
    next_clock_setup = clock_setup;
    next_conversion_result = conversion_result;
    next_irq_pending = irq_pending;
    next_first_done = first_done;
    next_state = state;
    next_tick_count = tick_count;
    if (bus.wr && bus.addr == OFF_CLOCK_SETUP) begin
      next_clock_setup = {bus.wdata[7:SRC_BIT], 4'h0};
    end
    if (status_wr || result_rd) begin
      next_irq_pending = 1'b0;
      next_status_control[DONE_BIT] = 1'b0;
    end
    if (status_wr) begin
      next_status_control[6:0] = bus.wdata[6:0];
      if (conv_irq_enable == 1'b1 && bus.wdata[IRQ_EN_BIT]) begin
        next_status_control[DONE_BIT] = bus.wdata[DONE_BIT];
      end
      next_first_done = 1'b0;
      next_tick_count = 5'h00;
      next_state = ST_SYNC;
    end else begin
      case (state)
        ST_IDLE: begin
          next_tick_count = 5'h00;
        end
        ST_SYNC: begin
          if (!powered) begin
            next_state = ST_IDLE;
          end else if (conv_tick) begin
            next_state = ST_CONV;
          end
        end
        ST_CONV: begin
          if (!powered) begin
            next_state = ST_IDLE;
          end else if (conv_tick) begin
            next_tick_count = tick_count + 5'h01;
            if (conv_done) begin
              next_tick_count = 5'h00;
              next_state = continuous_convert ? ST_CONV : ST_IDLE;
              if (is_external(channel_selector) || channel_selector == CH_REF_HIGH ||
                  channel_selector == CH_REF_LOW) begin
                next_conversion_result = core_sample_i;
              end else begin
                next_conversion_result = RESERVED_RESULT;
              end
              if (conv_irq_enable) begin
                next_irq_pending = 1'b1;
              end else if (!continuous_convert || !first_done) begin
                next_status_control[DONE_BIT] = 1'b1;
              end
              next_first_done = 1'b1;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_control <= RST_STATUS_CONTROL;
      clock_setup <= RST_CLOCK_SETUP;
      conversion_result <= RST_RESULT;
      irq_pending <= 1'b0;
      first_done <= 1'b0;
      state <= ST_IDLE;
      tick_count <= 5'h00;
    end else begin
      status_control <= next_status_control;
      clock_setup <= next_clock_setup;
      conversion_result <= next_conversion_result;
      irq_pending <= next_irq_pending;
      first_done <= next_first_done;
      state <= next_state;
      tick_count <= next_tick_count;
    end
  end

  // Read data, pin steering and core control
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == OFF_STATUS_CONTROL) begin
        next_rdata = status_control;
      end else if (bus.addr == OFF_RESULT) begin
        next_rdata = conversion_result;
      end else if (bus.addr == OFF_CLOCK_SETUP) begin
        next_rdata = clock_setup;
      end else begin
        next_rdata = 8'h00;
      end
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      next_pin_analog[i] = powered && channel_selector == 5'(i);
      next_port_read[i] = next_pin_analog[i] ? 1'b0 : port_in_i[i];
    end
    next_core_ctl.start = state == ST_SYNC && conv_tick && powered;
    next_core_ctl.mux = channel_selector[2:0];
    next_core_ctl.ref_high = channel_selector == CH_REF_HIGH;
    next_core_ctl.ref_low = channel_selector == CH_REF_LOW;
    next_core_ctl.power_on = powered;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      pin_analog_o <= '0;
      port_read_o <= '0;
      conv_irq_o <= 1'b0;
      core_ctl_o <= '0;
    end else begin
      rdata_o <= next_rdata;
      pin_analog_o <= next_pin_analog;
      port_read_o <= next_port_read;
      conv_irq_o <= next_irq_pending && conv_irq_enable && !status_control[DONE_BIT];
      core_ctl_o <= next_core_ctl;
    end
  end

  // Checks
  int_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_done && conv_irq_enable && !status_wr) |=> irq_pending)
    else $error("interrupt not raised at conversion end");
  int_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_wr || (result_rd && !conv_done)) |=> !irq_pending)
    else $error("interrupt not dropped on access");
  result_upd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_done && !status_wr && !is_external(channel_selector) && channel_selector != CH_REF_HIGH &&
     channel_selector != CH_REF_LOW) |=> conversion_result == RESERVED_RESULT)
    else $error("reserved channel result not zero");
  single_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_done && !continuous_convert && !status_wr) |=> state == ST_IDLE)
    else $error("single mode did not stop");
  cont_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_done && continuous_convert && powered && !status_wr) |=> state == ST_CONV)
    else $error("continuous mode stopped");
  power_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!powered && !status_wr) |=> state != ST_CONV)
    else $error("conversion while powered off");
  start_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    status_wr |=> state == ST_SYNC && tick_count == 5'h00)
    else $error("write did not start conversion");
  done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (result_rd && !status_wr && !conv_done) |=> !status_control[DONE_BIT])
    else $error("done flag not cleared by read");
  pin_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_analog_o[0] |-> port_read_o[0] == 1'b0)
    else $error("selected pin did not read zero");
  tick_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CONV |-> tick_count < CONV_TICKS)
    else $error("conversion length wrong");
endmodule : adcs_top

// ===== rtl/adcs_pkg.sv
// Package for the converter control block: offsets, fields, reset values, codes.
// Assumes a plain strobed register port on the CPU side.
package adcs_pkg;
  // Register offsets (byte addresses on the plain port)
  localparam logic [1:0] OFF_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] OFF_RESULT = 2'h1;
  localparam logic [1:0] OFF_CLOCK_SETUP = 2'h2;
  // Status/control field positions
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  // Clock setup field positions
  localparam int PRESC_LSB = 5;
  localparam int PRESC_W = 3;
  localparam int SRC_BIT = 4;
  // Reset values and the result for reserved channels
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h1F;
  localparam logic [7:0] RST_CLOCK_SETUP = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RESERVED_RESULT = 8'h00;
  // Channel codes
  localparam logic [4:0] CH_LAST_EXT = 5'h05;
  localparam logic [4:0] CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] CH_REF_LOW = 5'h1E;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;
  localparam int NUM_EXT = 6;
  // Conversion length in converter clock ticks (16 to 17)
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [7:0] FULL_SCALE = 8'hFF;
  localparam logic [7:0] ZERO_SCALE = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_CONV = 2'b10
  } adcs_state_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcs_bus_t;

  typedef struct packed {
    logic start;
    logic [2:0] mux;
    logic ref_high;
    logic ref_low;
    logic power_on;
  } adcs_core_ctl_t;
endpackage : adcs_pkg

// ===== testbench/adcs_top_bench.sv
// Self-checking bench for the converter control block.
// Assumes the plain strobed register port and a free bench crystal clock level.
`timescale 1ns/10ps
module adcs_top_bench;
  import adcs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic crystal_clock_i = 1'b0;
  logic [7:0] core_sample_i = 8'hA5;
  logic [5:0] port_in_i = 6'h3F;
  logic [5:0] pin_analog_o;
  logic [5:0] port_read_o;
  logic conv_irq_o;
  adcs_core_ctl_t core_ctl_o;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] rv;
  int n;
  logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
  int dv [7] = '{1, 2, 4, 8, 16, 16, 8};

  adcs_top dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .crystal_clock_i(crystal_clock_i), .core_sample_i(core_sample_i), .port_in_i(port_in_i),
    .pin_analog_o(pin_analog_o), .port_read_o(port_read_o), .conv_irq_o(conv_irq_o), .core_ctl_o(core_ctl_o));

  always #2.5 clk_i = ~clk_i;

  // Crystal level with a period of eight bus clocks
  always begin
    repeat (4) @(posedge clk_i);
    crystal_clock_i <= ~crystal_clock_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd_reg

  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (conv_irq_o !== 1'b1 && cnt < lim) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    if (cnt >= lim) begin
      fails++;
      $display("[ERR] irq_wait expected 1 seen timeout");
      conclude();
    end
  endtask : wait_irq

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("irq_reset", {7'h00, conv_irq_o}, 8'h00);
    rd_reg(OFF_STATUS_CONTROL, rv);
    check("status_reset", rv, 8'h1F);
    rd_reg(OFF_CLOCK_SETUP, rv);
    check("clock_reset", rv, 8'h00);
    rd_reg(OFF_RESULT, rv);
    check("result_reset", rv, 8'h00);
    rd_reg(2'h3, rv);
    check("unmapped", rv, 8'h00);
    // Prescaler codes 0 to 4 and 7 on the bus clock, code 0 on the crystal: length, result, interrupt clear
    for (int i = 0; i < 7; i++) begin
      wr_reg(OFF_CLOCK_SETUP, cfg[i]);
      rd_reg(OFF_CLOCK_SETUP, rv);
      check("clock_rb", rv, cfg[i]);
      core_sample_i <= 8'h11 * (i + 1);
      wr_reg(OFF_STATUS_CONTROL, 8'h40);
      wait_irq(2000, n);
      check("conv_len", 8'((n >= 16 * dv[i]) && (n <= 18 * dv[i] + 8)), 8'h01);
      rd_reg(OFF_RESULT, rv);
      check("result", rv, 8'(8'h11 * (i + 1)));
      repeat (2) @(posedge clk_i);
      check("irq_rd_clr", {7'h00, conv_irq_o}, 8'h00);
    end
    // Back to the fast bus clock source
    wr_reg(OFF_CLOCK_SETUP, 8'h10);
    // Interrupt dropped by a status write
    wr_reg(OFF_STATUS_CONTROL, 8'h40);
    wait_irq(100, n);
    wr_reg(OFF_STATUS_CONTROL, 8'h1F);
    repeat (2) @(posedge clk_i);
    check("irq_wr_clr", {7'h00, conv_irq_o}, 8'h00);
    // Single mode with flag polling, then stays idle
    core_sample_i <= 8'h5A;
    wr_reg(OFF_STATUS_CONTROL, 8'h00);
    repeat (30) @(posedge clk_i);
    rd_reg(OFF_STATUS_CONTROL, rv);
    check("done_set", rv, 8'h80);
    check("irq_off", {7'h00, conv_irq_o}, 8'h00);
    rd_reg(OFF_RESULT, rv);
    check("single_res", rv, 8'h5A);
    rd_reg(OFF_STATUS_CONTROL, rv);
    check("done_clr", rv, 8'h00);
    repeat (60) @(posedge clk_i);
    rd_reg(OFF_STATUS_CONTROL, rv);
    check("single_idle", rv, 8'h00);
    // Continuous mode refreshes the result without writes
    wr_reg(OFF_STATUS_CONTROL, 8'h62);
    wait_irq(100, n);
    rd_reg(OFF_RESULT, rv);
    check("cont_res1", rv, 8'h5A);
    core_sample_i <= 8'h3C;
    repeat (2) @(posedge clk_i);
    wait_irq(100, n);
    rd_reg(OFF_RESULT, rv);
    check("cont_res2", rv, 8'h3C);
    // External channels: pin claimed, reads zero, mux code
    for (int c = 0; c < 6; c++) begin
      wr_reg(OFF_STATUS_CONTROL, 8'(c));
      repeat (3) @(posedge clk_i);
      check("pin_analog", {2'b00, pin_analog_o}, 8'(1 << c));
      check("port_read", {2'b00, port_read_o}, 8'(6'h3F & ~(6'h01 << c)));
      check("mux", {5'h00, core_ctl_o.mux}, 8'(c));
      check("power_on", {7'h00, core_ctl_o.power_on}, 8'h01);
    end
    // Reserved code gives a defined zero result
    wr_reg(OFF_STATUS_CONTROL, 8'h46);
    wait_irq(100, n);
    rd_reg(OFF_RESULT, rv);
    check("reserved_res", rv, RESERVED_RESULT);
    check("reserved_pins", {2'b00, pin_analog_o}, 8'h00);
    // Reference nodes
    wr_reg(OFF_STATUS_CONTROL, {3'b000, CH_REF_HIGH});
    repeat (3) @(posedge clk_i);
    check("ref_high", {6'h00, core_ctl_o.ref_high, core_ctl_o.ref_low}, 8'h02);
    wr_reg(OFF_STATUS_CONTROL, {3'b000, CH_REF_LOW});
    repeat (3) @(posedge clk_i);
    check("ref_low", {6'h00, core_ctl_o.ref_high, core_ctl_o.ref_low}, 8'h01);
    // Power-off code: no conversions, no interrupt
    wr_reg(OFF_STATUS_CONTROL, 8'h5F);
    repeat (60) @(posedge clk_i);
    check("off_power", {7'h00, core_ctl_o.power_on}, 8'h00);
    check("off_irq", {7'h00, conv_irq_o}, 8'h00);
    rd_reg(OFF_STATUS_CONTROL, rv);
    check("off_status", rv, 8'h5F);
    // Result register ignores writes
    wr_reg(OFF_RESULT, 8'hC3);
    rd_reg(OFF_RESULT, rv);
    check("result_ro", rv, 8'h00);
    // Leaving power-off: first result discarded, second one trusted
    core_sample_i <= 8'h77;
    wr_reg(OFF_STATUS_CONTROL, 8'h40);
    wait_irq(100, n);
    rd_reg(OFF_RESULT, rv);
    wr_reg(OFF_STATUS_CONTROL, 8'h40);
    wait_irq(100, n);
    rd_reg(OFF_RESULT, rv);
    check("wake_res", rv, 8'h77);
    conclude();
  end

  initial begin
    #400000;
    fails++;
    $display("[ERR] run expected finish seen timeout");
    conclude();
  end
endmodule : adcs_top_bench
